// >>> daq_io_pkg.sv
/*
  Package for the board's host I/O register decode: register offsets,
  address field positions, interrupt line selection codes and carriers.
  Assumes an 8-bit host I/O channel with a 10-bit I/O address.
*/
package daq_io_pkg;

  localparam int ADDR_W  = 10;
  localparam int DATA_W  = 8;
  localparam int OFS_W   = 5;
  localparam int BASE_W  = 5;
  localparam int ADC_W   = 12;
  localparam int IRQ_N   = 6;

  // Register offsets within the board's window.
  localparam logic [OFS_W-1:0] OFS_CMD1_STAT1 = 5'h00;
  localparam logic [OFS_W-1:0] OFS_CLR_STAT2  = 5'h01;
  localparam logic [OFS_W-1:0] OFS_FIFO_LO    = 5'h02;
  localparam logic [OFS_W-1:0] OFS_FIFO_HI    = 5'h03;
  localparam logic [OFS_W-1:0] OFS_DOUT       = 5'h04;
  localparam logic [OFS_W-1:0] OFS_CMD3_DIN   = 5'h05;
  localparam logic [OFS_W-1:0] OFS_TMR_CLR    = 5'h06;
  localparam logic [OFS_W-1:0] OFS_CMD2       = 5'h07;
  localparam logic [OFS_W-1:0] OFS_CNT0       = 5'h08;
  localparam logic [OFS_W-1:0] OFS_CNT1       = 5'h09;
  localparam logic [OFS_W-1:0] OFS_CNT2       = 5'h0A;
  localparam logic [OFS_W-1:0] OFS_CNT_MODE   = 5'h0B;

  // Address field positions: register select and base compare.
  localparam int OFS_LSB  = 0;
  localparam int BASE_LSB = 5;

  // Lowest legal base address field (0x100 >> 5).
  localparam logic [BASE_W-1:0] BASE_MIN = 5'h08;

  // Interrupt line selection codes; any other code means no line.
  localparam logic [2:0] IRQ_SEL_NONE = 3'h0;
  localparam logic [2:0] IRQ_SEL_3    = 3'h1;
  localparam logic [2:0] IRQ_SEL_4    = 3'h2;
  localparam logic [2:0] IRQ_SEL_5    = 3'h3;
  localparam logic [2:0] IRQ_SEL_6    = 3'h4;
  localparam logic [2:0] IRQ_SEL_7    = 3'h5;
  localparam logic [2:0] IRQ_SEL_9    = 3'h6;
  localparam logic [2:0] IRQ_SEL_DEF  = IRQ_SEL_5;

  localparam logic [DATA_W-1:0] REG_RST  = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE = 8'hFF;

  // Host bus cycle as seen by the board.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              rd;
    logic              wr;
  } host_cycle_t;

  // One-cycle event strobes toward the board's function blocks.
  typedef struct packed {
    logic adc_clear;
    logic timer_irq_clear;
    logic fifo_lo_read;
    logic fifo_hi_read;
    logic cnt_mode_wr;
    logic [2:0] cnt_wr;
    logic [2:0] cnt_rd;
  } event_t;

endpackage

// >>> irq_line_steer.sv
/*
  Steers one board interrupt request onto at most one of six host lines.
  Assumes the selection code is a stable jumper setting.
*/
`timescale 1ns/10ps
`default_nettype none
module irq_line_steer
  import daq_io_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [2:0]       sel,
  input  wire logic             req,
  output logic [IRQ_N-1:0]      irq_out
);

  // Registered so the line never glitches during a jumper change.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_out <= '0;
    end else begin
      irq_out <= '0;
      case (sel)
        IRQ_SEL_3: irq_out[0] <= req;
        IRQ_SEL_4: irq_out[1] <= req;
        IRQ_SEL_5: irq_out[2] <= req;
        IRQ_SEL_6: irq_out[3] <= req;
        IRQ_SEL_7: irq_out[4] <= req;
        IRQ_SEL_9: irq_out[5] <= req;
        default:   irq_out <= '0; // No line selected: stay quiet.
      endcase
    end
  end

  chk_irq_onehot: assert property (@(posedge clk) disable iff (!arst_n) $onehot0(irq_out))
    else $error("more than one interrupt line driven");
  chk_irq_none: assert property (@(posedge clk) disable iff (!arst_n)
    $past(sel) == IRQ_SEL_NONE |-> irq_out == '0)
    else $error("interrupt driven with no line selected");

endmodule
`default_nettype wire

// >>> daq_io_decode.sv
/*
  Host I/O register decode for a data-acquisition board: thirty-two byte
  offsets above a switch-selected base, with separate read and write maps.
  Assumes host strobes are one-cycle pulses synchronous to clk and that
  the converter, counter chip and digital port sit outside this block.
*/
// What this block does
// - The interrupt request goes to exactly one chosen line among IRQ3 to IRQ7 and IRQ9.
// - With no line chosen, no interrupt line is asserted, except IRQ5 in the first clock after reset.
// - The interrupt line chosen in the first clock after reset is IRQ5; after that the irq_sel jumper chooses it.
// - Offset 0 writes command one and reads status one, offset 7 is command two both ways, offset 5 writes command three, offset 1 reads status two.
// - Offsets 2 and 3 read the low and high FIFO bytes, and a write to offset 1 clears the converter.
// - Offsets 8, 9 and A reach counter data both ways and offset B writes the counter mode.
// - A write to offset 6 clears the pending timer interrupt.
// - A write to offset 4 sets the digital output byte and a read at offset 5 returns the digital input byte.
// - Every register is one byte and wider values take two byte accesses.
// - The host data path is eight bits wide.
// - Conversion codes are 12 bits and the range meaning is left to software.
// - A4 to A0 select the register and A9 to A5 are compared with the base switches.
// - A write to offset 1 or 6 fires the event and its data is ignored; writes to offsets 8 to B also load their byte into cnt_wdata.
`timescale 1ns/10ps
`default_nettype none
module daq_io_decode
  import daq_io_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire host_cycle_t         host,
  input  wire logic [BASE_W-1:0]   base_sw,
  input  wire logic [2:0]          irq_sel,
  output logic [DATA_W-1:0]        rdata,
  output logic                     rdata_oe,
  input  wire logic [DATA_W-1:0]   status_one,
  input  wire logic [DATA_W-1:0]   status_two,
  input  wire logic [ADC_W-1:0]    fifo_code,
  input  wire logic [DATA_W-1:0]   digital_in,
  input  wire logic [DATA_W-1:0]   cnt_rdata,
  output logic [DATA_W-1:0]        cnt_wdata,
  input  wire logic                board_irq,
  output logic [DATA_W-1:0]        command_one,
  output logic [DATA_W-1:0]        command_two,
  output logic [DATA_W-1:0]        command_three,
  output logic [DATA_W-1:0]        digital_out,
  output event_t                   events,
  output logic [IRQ_N-1:0]         irq_out
);

  logic              hit;
  logic [OFS_W-1:0]  ofs;
  logic              rd_hit;
  logic              wr_hit;
  logic [DATA_W-1:0] nxt_rdata;
  logic              nxt_rdata_oe;
  logic [2:0]        irq_sel_ff;
  logic [DATA_W-1:0] fifo_hi_hold_ff;

  // Base compare on the upper lines, register select on the lower five.
  // The low base window is refused even if the switches point there.
  assign ofs    = host.addr[OFS_LSB +: OFS_W];
  assign hit    = (host.addr[BASE_LSB +: BASE_W] == base_sw) && (base_sw >= BASE_MIN);
  assign rd_hit = hit && host.rd;
  assign wr_hit = hit && host.wr;

  // Interrupt selection defaults to line five and then follows the jumper.
  // Capturing it on a clock keeps the async reset constant-only.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_sel_ff <= IRQ_SEL_DEF;
    end else begin
      irq_sel_ff <= irq_sel;
    end
  end

  irq_line_steer u_irq (
    .clk     (clk),
    .arst_n  (arst_n),
    .sel     (irq_sel_ff),
    .req     (board_irq),
    .irq_out (irq_out)
  );

  // Write-side byte registers; each holds exactly one host byte.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      command_one   <= REG_RST;
      command_two   <= REG_RST;
      command_three <= REG_RST;
      digital_out   <= REG_RST;
      cnt_wdata     <= REG_RST;
    end else if (wr_hit) begin
      case (ofs)
        OFS_CMD1_STAT1: command_one   <= host.wdata;
        OFS_CMD2:       command_two   <= host.wdata;
        OFS_CMD3_DIN:   command_three <= host.wdata;
        OFS_DOUT:       digital_out   <= host.wdata;
        OFS_CNT0, OFS_CNT1, OFS_CNT2, OFS_CNT_MODE:
                        cnt_wdata     <= host.wdata;
        default:        ;
      endcase
    end
  end

  // Event strobes last one cycle; the written byte never reaches them.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      events <= '0;
    end else begin
      events                 <= '0;
      events.adc_clear       <= wr_hit && (ofs == OFS_CLR_STAT2);
      events.timer_irq_clear <= wr_hit && (ofs == OFS_TMR_CLR);
      events.cnt_mode_wr     <= wr_hit && (ofs == OFS_CNT_MODE);
      events.fifo_lo_read    <= rd_hit && (ofs == OFS_FIFO_LO);
      events.fifo_hi_read    <= rd_hit && (ofs == OFS_FIFO_HI);
      events.cnt_wr[0]       <= wr_hit && (ofs == OFS_CNT0);
      events.cnt_wr[1]       <= wr_hit && (ofs == OFS_CNT1);
      events.cnt_wr[2]       <= wr_hit && (ofs == OFS_CNT2);
      events.cnt_rd[0]       <= rd_hit && (ofs == OFS_CNT0);
      events.cnt_rd[1]       <= rd_hit && (ofs == OFS_CNT1);
      events.cnt_rd[2]       <= rd_hit && (ofs == OFS_CNT2);
    end
  end

  // The high byte is latched when the low byte is read, so a FIFO that
  // advances on the low read still pairs the two halves of one code.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fifo_hi_hold_ff <= REG_RST;
    end else if (rd_hit && (ofs == OFS_FIFO_LO)) begin
      fifo_hi_hold_ff <= {{(2*DATA_W-ADC_W){1'b0}}, fifo_code[ADC_W-1:DATA_W]};
    end
  end

  // Read map; write-only offsets answer with idle data and touch nothing.
  // The map is applied only on a read hit, so an idle bus or a cycle aimed
  // at another card always shows the idle byte and leaks no register.
  always_comb begin
    nxt_rdata    = READ_IDLE;
    nxt_rdata_oe = rd_hit;
    if (rd_hit) begin
      case (ofs)
        OFS_CMD1_STAT1: nxt_rdata = status_one;
        OFS_CLR_STAT2:  nxt_rdata = status_two;
        OFS_FIFO_LO:    nxt_rdata = fifo_code[DATA_W-1:0];
        OFS_FIFO_HI:    nxt_rdata = fifo_hi_hold_ff;
        OFS_CMD3_DIN:   nxt_rdata = digital_in;
        OFS_CMD2:       nxt_rdata = command_two;
        OFS_CNT0, OFS_CNT1, OFS_CNT2:
                        nxt_rdata = cnt_rdata;
        default:        nxt_rdata = READ_IDLE;
      endcase
    end
  end

  // Registered byte-wide read data path.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata    <= READ_IDLE;
      rdata_oe <= 1'b0;
    end else begin
      rdata    <= nxt_rdata;
      rdata_oe <= nxt_rdata_oe;
    end
  end

  chk_cmd1_load: assert property (@(posedge clk) disable iff (!arst_n)
    wr_hit && ofs == OFS_CMD1_STAT1 |=> command_one == $past(host.wdata))
    else $error("command one not loaded");
  chk_cmd2_readback: assert property (@(posedge clk) disable iff (!arst_n)
    rd_hit && ofs == OFS_CMD2 |=> rdata == $past(command_two) && rdata_oe)
    else $error("command two readback wrong");
  chk_adc_clear: assert property (@(posedge clk) disable iff (!arst_n)
    events.adc_clear |-> $past(wr_hit) && $past(ofs) == OFS_CLR_STAT2)
    else $error("converter clear without its write");
  chk_timer_clear: assert property (@(posedge clk) disable iff (!arst_n)
    wr_hit && ofs == OFS_TMR_CLR |=> events.timer_irq_clear ##1 !events.timer_irq_clear)
    else $error("timer clear strobe wrong");
  chk_dout_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !(wr_hit && ofs == OFS_DOUT) |=> $stable(digital_out))
    else $error("digital output changed without a write");
  chk_din_read: assert property (@(posedge clk) disable iff (!arst_n)
    rd_hit && ofs == OFS_CMD3_DIN |=> rdata == $past(digital_in))
    else $error("digital input not returned");
  chk_cnt_mode: assert property (@(posedge clk) disable iff (!arst_n)
    wr_hit && ofs == OFS_CNT_MODE |=> events.cnt_mode_wr && cnt_wdata == $past(host.wdata))
    else $error("counter mode write lost");
  chk_fifo_pair: assert property (@(posedge clk) disable iff (!arst_n)
    rd_hit && ofs == OFS_FIFO_LO |=> fifo_hi_hold_ff[ADC_W-DATA_W-1:0] == $past(fifo_code[ADC_W-1:DATA_W]))
    else $error("high byte not paired with low byte");
  chk_base_miss: assert property (@(posedge clk) disable iff (!arst_n)
    !hit |=> !rdata_oe && $stable(command_one) && !events.adc_clear)
    else $error("access outside base window acted");
  chk_wo_read: assert property (@(posedge clk) disable iff (!arst_n)
    rd_hit && !wr_hit && (ofs == OFS_DOUT || ofs == OFS_TMR_CLR) |=> $stable(digital_out) && !events.timer_irq_clear)
    else $error("read of write-only location had effect");
  chk_irq_default: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(arst_n) |-> irq_sel_ff == IRQ_SEL_DEF)
    else $error("interrupt selection not default after reset");

endmodule
`default_nettype wire

// >>> host_bus_model.sv
/*
  Host processor model for the board's I/O channel: byte-wide read and
  write cycles. Assumes the bench calls its tasks and shares its clock.
*/
`timescale 1ns/10ps
`default_nettype none
module host_bus_model
  import daq_io_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [BASE_W-1:0] base_sel,
  input  wire logic [DATA_W-1:0] rdata,
  input  wire logic              rdata_oe,
  output var host_cycle_t        host
);
  // The bus starts idle; strobes stay low between cycles.
  initial host = '{addr: 10'h000, wdata: 8'h00, rd: 1'b0, wr: 1'b0};

  // One byte per cycle, so wide values take two calls, low byte first.
  // Address and data flip once released so stale values never look valid.
  task automatic io_write(input logic [OFS_W-1:0] ofs, input logic [DATA_W-1:0] d);
    @(negedge clk);
    host.addr  = {base_sel, ofs};
    host.wdata = d;
    host.wr    = 1'b1;
    @(negedge clk);
    host.wr    = 1'b0;
    host.addr  = ~host.addr;
    host.wdata = ~d;
  endtask

  // Read data is taken one cycle after the strobe edge.
  task automatic io_read(input logic [OFS_W-1:0] ofs, output logic [DATA_W-1:0] d,
                         output logic oe);
    @(negedge clk);
    host.addr = {base_sel, ofs};
    host.rd   = 1'b1;
    @(negedge clk);
    host.rd   = 1'b0;
    host.addr = ~host.addr;
    d         = rdata;
    oe        = rdata_oe;
  endtask
endmodule
`default_nettype wire

// >>> test_daq_io_decode.sv
/*
  Self-checking bench for the host register decode: register map, events,
  refusals and interrupt steering. Assumes the host model drives the bus.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module test_daq_io_decode
  import daq_io_pkg::*;
;
  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic [BASE_W-1:0] base_sw, host_base;
  logic [2:0]        irq_sel;
  logic [DATA_W-1:0] status_one, status_two, digital_in, cnt_rdata, rdata, cnt_wdata;
  logic [DATA_W-1:0] command_one, command_two, command_three, digital_out, rd_d;
  logic [ADC_W-1:0]  fifo_code;
  logic              board_irq, rdata_oe, rd_oe;
  logic [IRQ_N-1:0]  irq_out;
  host_cycle_t       host;
  event_t            events;
  int                mismatches = 0;
  int                checks = 0;
  logic [OFS_W-1:0]  ev_ofs [6] = '{5'h01, 5'h06, 5'h0B, 5'h08, 5'h09, 5'h0A};
  event_t            ev_exp [6] = '{11'h400, 11'h200, 11'h040, 11'h008, 11'h010, 11'h020};
  logic [OFS_W-1:0]  wo_ofs [3] = '{5'h04, 5'h06, 5'h0B};

  // Free-running 200 MHz clock.
  always #2.5 clk = ~clk;

  daq_io_decode dut_u (.clk(clk), .arst_n(arst_n), .host(host), .base_sw(base_sw),
    .irq_sel(irq_sel), .rdata(rdata), .rdata_oe(rdata_oe), .status_one(status_one),
    .status_two(status_two), .fifo_code(fifo_code), .digital_in(digital_in),
    .cnt_rdata(cnt_rdata), .cnt_wdata(cnt_wdata), .board_irq(board_irq),
    .command_one(command_one), .command_two(command_two), .command_three(command_three),
    .digital_out(digital_out), .events(events), .irq_out(irq_out));

  host_bus_model host_u (.clk(clk), .base_sel(host_base), .rdata(rdata),
    .rdata_oe(rdata_oe), .host(host));

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic rd_chk(input logic [OFS_W-1:0] ofs, input logic [DATA_W-1:0] exp);
    host_u.io_read(ofs, rd_d, rd_oe);
    `CHK(rd_d, exp)
  endtask

  task automatic wr_now(input logic [OFS_W-1:0] ofs, input logic [DATA_W-1:0] d);
    host_u.io_write(ofs, d);
  endtask

  // Reset is pulsed on a falling edge so it never races the sampling edge.
  task automatic pulse_reset();
    arst_n = 1'b0;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
  endtask

  // A hung run is cut short here and counted as a failure.
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report();
  end

  // Main sequence.
  initial begin
    base_sw = 5'h13; host_base = 5'h13; irq_sel = IRQ_SEL_5; board_irq = 1'b0;
    status_one = 8'h81; status_two = 8'h42; digital_in = 8'h96; cnt_rdata = 8'h00;
    fifo_code = 12'h000;
    pulse_reset();
    `CHK(command_two, REG_RST)
    `CHK(rdata_oe, 1'b0)
    wr_now(OFS_CMD1_STAT1, 8'hA5); `CHK(command_one, 8'hA5)
    wr_now(OFS_CMD2, 8'h3C); `CHK(command_two, 8'h3C)
    wr_now(OFS_CMD3_DIN, 8'h5A); `CHK(command_three, 8'h5A)
    `CHK(digital_out, REG_RST)
    wr_now(OFS_DOUT, 8'hC3); `CHK(digital_out, 8'hC3)
    rd_chk(OFS_CMD1_STAT1, 8'h81); `CHK(rd_oe, 1'b1)
    rd_chk(OFS_CLR_STAT2, 8'h42);
    rd_chk(OFS_CMD2, 8'h3C);
    rd_chk(OFS_CMD3_DIN, 8'h96);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      wr_now(ev_ofs[i], 8'h21 * i[7:0] + 8'h0F);
      `CHK(events, ev_exp[i])
      if (i > 1) `CHK(cnt_wdata, 8'h21 * i[7:0] + 8'h0F)
      @(negedge clk); `CHK(events, event_t'(11'h000))
    end
    for (int k = 0; k < 3; k++) begin
      cnt_rdata = 8'h70 + k[7:0];
      rd_chk(OFS_CNT0 + k[4:0], 8'h70 + k[7:0]);
      `CHK(events, event_t'(11'h001 << k))
    end
    $display("test events done");
    fifo_code = 12'hABC;
    rd_chk(OFS_FIFO_LO, 8'hBC); `CHK(events.fifo_lo_read, 1'b1)
    fifo_code = 12'h123;
    rd_chk(OFS_FIFO_HI, 8'h0A); `CHK(events.fifo_hi_read, 1'b1)
    $display("test fifo done");
    for (int j = 0; j < 3; j++) begin
      rd_chk(wo_ofs[j], READ_IDLE); `CHK(events, event_t'(11'h000))
    end
    `CHK(digital_out, 8'hC3)
    rd_chk(5'h0C, READ_IDLE);
    rd_chk(5'h1F, READ_IDLE);
    host_base = 5'h14;
    rd_chk(OFS_CMD2, READ_IDLE); `CHK(rd_oe, 1'b0)
    wr_now(OFS_CMD2, 8'h00); `CHK(command_two, 8'h3C)
    base_sw = 5'h04; host_base = 5'h04;
    wr_now(OFS_CMD2, 8'h00); `CHK(command_two, 8'h3C)
    rd_chk(OFS_CMD2, READ_IDLE); `CHK(rd_oe, 1'b0)
    base_sw = 5'h13; host_base = 5'h13;
    $display("test refusals done");
    for (int c = 0; c < 8; c++) begin
      irq_sel = c[2:0];
      board_irq = 1'b1;
      pulse_reset();
      repeat (3) @(negedge clk);
      `CHK(irq_out, (c >= 1 && c <= 6) ? 6'h01 << (c - 1) : 6'h00)
      board_irq = 1'b0;
      repeat (2) @(negedge clk);
      `CHK(irq_out, 6'h00)
    end
    $display("test interrupts done");
    final_report();
  end
endmodule
`undef CHK
`default_nettype wire
